// ---- design/cfg_src_pkg.sv ----
// constants for the descriptor configuration source block
package cfg_src_pkg;
  localparam int MAC_HI_W = 16;
  localparam int MAC_LO_W = 32;
  localparam int WAKE_W = 11;
  localparam int LEN_W = 32;
  localparam int FLAG_W = 8;
  localparam int EE_AW = 8;
  // eeprom image byte offsets
  localparam logic [7:0] EE_MAC_BASE = 8'h01;
  localparam logic [7:0] EE_HS_LEN = 8'h16;
  localparam logic [7:0] EE_FS_LEN = 8'h1a;
  localparam logic [7:0] EE_STR_LEN = 8'h0c;
  localparam logic [7:0] EE_WAKE_LO = 8'h1e;
  localparam logic [7:0] EE_WAKE_HI = 8'h1f;
  localparam logic [7:0] EE_FLAGS = 8'h20;
  localparam logic [7:0] EE_CFG = 8'h0a;
  localparam logic [7:0] EE_HIGH_SPEED_DESC_LENGTHS = 8'h65;
  localparam logic [7:0] EE_IMAGE_END = 8'h93;
  localparam logic [7:0] EE_HOST_BASE = 8'h94;
  localparam int LED_FUNCTION_SELECT_BIT = 2;
  localparam int WAKEUP_BIT = 5;
  localparam logic [7:0] FLAGS_RST = 8'h00;
  localparam logic [7:0] LOAD_LAST = 8'h93;
  typedef enum logic [1:0] {
    ST_IDLE = 2'b00,
    ST_LOAD = 2'b01,
    ST_DONE = 2'b11
  } load_e;
endpackage

// ---- design/ee_byte_if.sv ----
// byte fetch channel between the loader and its eeprom reader
`timescale 1ns/100ps
`default_nettype none
interface ee_byte_if;
  logic req;
  logic [7:0] addr;
  logic ack;
  logic [7:0] data;
  modport loader (output req, output addr, input ack, input data);
  modport reader (input req, input addr, output ack, output data);
endinterface
`default_nettype wire

// ---- design/ee_reader.sv ----
// eeprom byte reader: one-cycle request to registered answer
`timescale 1ns/100ps
`default_nettype none
module ee_reader
  import cfg_src_pkg::*;
(
  input wire logic clk,
  input wire logic rst,
  ee_byte_if.reader bus,
  output logic ee_rd,
  output logic [7:0] ee_addr,
  input wire logic ee_valid,
  input wire logic [7:0] ee_rdata
);
  logic busy;

  // one read in flight at a time; a second strobe before the answer
  // would fetch the same address twice
  always_ff @(posedge clk)
  begin
    if (rst)
    begin
      ee_rd <= 1'b0;
      ee_addr <= 8'h00;
      busy <= 1'b0;
      bus.ack <= 1'b0;
      bus.data <= 8'h00;
    end
    else
    begin
      ee_rd <= bus.req & ~busy & ~bus.ack;
      ee_addr <= bus.addr;
      busy <= (busy & ~bus.ack) | (bus.req & ~busy & ~bus.ack);
      bus.ack <= ee_valid;
      bus.data <= ee_rdata;
    end
  end
endmodule
`default_nettype wire

// ---- design/cfg_source.sv ----
// descriptor and settings source selection: eeprom image or software load
// Behaviour
// - only attributes written after ram fill let wakeup flag follow config attributes
// - with eeprom hardware loads mac, led select and wake enables itself
// - a flag attribute register holds stand-alone config and wake flags
// - in eeprom mode flags come from eeprom, software cannot see or change
// - eeprom bytes past the descriptor image are never interpreted
// - ram, attributes and software fields are an alternative source
// - emulation enable selects ram, attributes and software fields
// - reset protection keeps settings through every reset but power-on
`timescale 1ns/100ps
`default_nettype none
module cfg_source
  import cfg_src_pkg::*;
(
  input wire logic clk,
  input wire logic rst,
  input wire logic por,
  input wire logic eeprom_present,
  input wire logic eeprom_emulation_enable,
  input wire logic reset_protect,
  input wire logic sw_wr,
  input wire logic [cfg_src_pkg::MAC_HI_W-1:0] sw_mac_address_high,
  input wire logic [cfg_src_pkg::MAC_LO_W-1:0] sw_mac_address_low,
  input wire logic sw_led_function_select,
  input wire logic [cfg_src_pkg::WAKE_W-1:0] sw_gpio_wake_enable_n,
  input wire logic [cfg_src_pkg::LEN_W-1:0] sw_high_speed_desc_lengths,
  input wire logic [cfg_src_pkg::LEN_W-1:0] sw_full_speed_desc_lengths,
  input wire logic [cfg_src_pkg::FLAG_W-1:0] sw_flag_attribute_reg,
  input wire logic sw_cfg_attr_wr,
  input wire logic [7:0] sw_cfg_attr,
  output logic ee_rd,
  output logic [7:0] ee_addr,
  input wire logic ee_valid,
  input wire logic [7:0] ee_rdata,
  output logic [cfg_src_pkg::MAC_HI_W-1:0] mac_address_high,
  output logic [cfg_src_pkg::MAC_LO_W-1:0] mac_address_low,
  output logic led_function_select,
  output logic [cfg_src_pkg::WAKE_W-1:0] gpio_wake_enable_n,
  output logic [cfg_src_pkg::LEN_W-1:0] high_speed_desc_lengths,
  output logic [cfg_src_pkg::LEN_W-1:0] full_speed_desc_lengths,
  output logic [cfg_src_pkg::FLAG_W-1:0] flag_attribute_reg,
  output logic [cfg_src_pkg::FLAG_W-1:0] flag_readback,
  output logic remote_wakeup_flag,
  output logic source_is_ram,
  output logic load_done
);
  import cfg_src_pkg::*;

  ee_byte_if bus ();
  load_e state;
  load_e next_state;
  logic [7:0] ptr;
  logic [7:0] next_ptr;
  logic boot_ram;
  logic emu_s0;
  logic emu_s1;
  logic pres_s0;
  logic pres_s1;
  logic attr_seen;
  logic keep;

  ee_reader reader (
    .clk(clk),
    .rst(rst),
    .bus(bus),
    .ee_rd(ee_rd),
    .ee_addr(ee_addr),
    .ee_valid(ee_valid),
    .ee_rdata(ee_rdata)
  );

  // pins come from another domain, so two stages before use
  always_ff @(posedge clk)
  begin
    emu_s0 <= eeprom_emulation_enable;
    emu_s1 <= emu_s0;
    pres_s0 <= eeprom_present;
    pres_s1 <= pres_s0;
  end

  // protected settings survive a warm reset, never a power-on one
  assign keep = rst & reset_protect & ~por;

  // fetch sequencer walks only the descriptor image region
  assign bus.req = (state == ST_LOAD);
  assign bus.addr = ptr;
  always_comb
  begin
    next_state = state;
    next_ptr = ptr;
    unique case (state)
      ST_IDLE:
      begin
        if (!emu_s1 && pres_s1)
        begin
          next_state = ST_LOAD;
        end
      end
      ST_LOAD:
      begin
        if (bus.ack)
        begin
          if (ptr == LOAD_LAST)
          begin
            next_state = ST_DONE;
          end
          else
          begin
            next_ptr = ptr + 8'h01;
          end
        end
      end
      ST_DONE:
      begin
        next_state = ST_DONE;
      end
      default:
      begin
        next_state = ST_IDLE;
      end
    endcase
  end

  // source latched once per boot so the two never mix
  always_ff @(posedge clk)
  begin
    if (rst)
    begin
      state <= ST_IDLE;
      ptr <= 8'h00;
      boot_ram <= 1'b0;
      load_done <= 1'b0;
      source_is_ram <= 1'b0;
    end
    else
    begin
      state <= next_state;
      ptr <= next_ptr;
      if (state == ST_IDLE && emu_s1)
      begin
        boot_ram <= 1'b1;
        load_done <= 1'b1;
      end
      else if (next_state == ST_DONE)
      begin
        load_done <= 1'b1;
      end
      source_is_ram <= boot_ram;
    end
  end

  // settings: eeprom bytes or software writes, chosen by boot source
  always_ff @(posedge clk)
  begin
    if (rst && !keep)
    begin
      mac_address_high <= '0;
      mac_address_low <= '0;
      led_function_select <= 1'b0;
      gpio_wake_enable_n <= '0;
      high_speed_desc_lengths <= '0;
      full_speed_desc_lengths <= '0;
      flag_attribute_reg <= FLAGS_RST;
      attr_seen <= 1'b0;
    end
    else if (!rst)
    begin
      if (sw_wr && (boot_ram || (state == ST_IDLE && emu_s1)))
      begin
        mac_address_high <= sw_mac_address_high;
        mac_address_low <= sw_mac_address_low;
        led_function_select <= sw_led_function_select;
        gpio_wake_enable_n <= sw_gpio_wake_enable_n;
        high_speed_desc_lengths <= sw_high_speed_desc_lengths;
        full_speed_desc_lengths <= sw_full_speed_desc_lengths;
        flag_attribute_reg <= sw_flag_attribute_reg;
        attr_seen <= 1'b1;
      end
      else if (state == ST_LOAD && bus.ack)
      begin
        // byte placement from eeprom image; software writes ignored here
        if (ptr >= EE_MAC_BASE && ptr < EE_MAC_BASE + 8'h04)
        begin
          mac_address_low[(ptr - EE_MAC_BASE) * 8 +: 8] <= bus.data;
        end
        if (ptr == EE_MAC_BASE + 8'h04)
        begin
          mac_address_high[7:0] <= bus.data;
        end
        if (ptr == EE_MAC_BASE + 8'h05)
        begin
          mac_address_high[15:8] <= bus.data;
        end
        if (ptr == EE_CFG)
        begin
          led_function_select <= bus.data[LED_FUNCTION_SELECT_BIT];
        end
        if (ptr == EE_WAKE_LO)
        begin
          gpio_wake_enable_n[7:0] <= bus.data;
        end
        if (ptr == EE_WAKE_HI)
        begin
          gpio_wake_enable_n[10:8] <= bus.data[2:0];
        end
        if (ptr == EE_FLAGS)
        begin
          flag_attribute_reg <= bus.data;
        end
        if (ptr == EE_HS_LEN)
        begin
          high_speed_desc_lengths[7:0] <= bus.data;
        end
        if (ptr == EE_FS_LEN)
        begin
          full_speed_desc_lengths[7:0] <= bus.data;
        end
      end
    end
  end

  // software sees flags only when it owns them
  always_ff @(posedge clk)
  begin
    if (rst)
    begin
      flag_readback <= '0;
    end
    else
    begin
      flag_readback <= boot_ram ? flag_attribute_reg : '0;
    end
  end

  // wakeup flag follows config attributes only after lengths are set
  always_ff @(posedge clk)
  begin
    if (rst && !keep)
    begin
      remote_wakeup_flag <= 1'b0;
    end
    else if (!rst)
    begin
      if (boot_ram && sw_cfg_attr_wr && attr_seen)
      begin
        remote_wakeup_flag <= sw_cfg_attr[WAKEUP_BIT];
      end
      else if (state == ST_LOAD && bus.ack && ptr == EE_HIGH_SPEED_DESC_LENGTHS)
      begin
        remote_wakeup_flag <= bus.data[WAKEUP_BIT];
      end
    end
  end

  // load never reads into the host storage area
  no_host_read_a: assert property (@(posedge clk) disable iff (rst)
    ee_rd |-> ee_addr < EE_HOST_BASE) else $error("host area read");
  ram_no_fetch_a: assert property (@(posedge clk) disable iff (rst)
    source_is_ram |-> !ee_rd) else $error("fetch in ram mode");
  flag_hidden_a: assert property (@(posedge clk) disable iff (rst)
    !boot_ram |=> flag_readback == 8'h00) else $error("flags visible");
  sw_takes_a: assert property (@(posedge clk) disable iff (rst)
    (boot_ram && sw_wr) |=> mac_address_low == $past(sw_mac_address_low))
    else $error("software value lost");
  ee_mac_a: assert property (@(posedge clk) disable iff (rst)
    (state == ST_LOAD && bus.ack && ptr == EE_MAC_BASE)
    |=> mac_address_low[7:0] == $past(bus.data)) else $error("mac not loaded");
  src_stable_a: assert property (@(posedge clk) disable iff (rst)
    boot_ram |=> boot_ram) else $error("source changed in boot");
  wake_order_a: assert property (@(posedge clk) disable iff (rst)
    (boot_ram && sw_cfg_attr_wr && !attr_seen && !(state == ST_LOAD))
    |=> $stable(remote_wakeup_flag)) else $error("wakeup before attributes");
  flag_ee_a: assert property (@(posedge clk) disable iff (rst)
    (state == ST_LOAD && bus.ack && ptr == EE_FLAGS)
    |=> flag_attribute_reg == $past(bus.data)) else $error("flags not loaded");
endmodule
`default_nettype wire

// ---- tb/cfg_source_tb.sv ----
// self-checking bench for the descriptor configuration source block
`timescale 1ns/100ps
`default_nettype none
module cfg_source_tb;
  import cfg_src_pkg::*;
  logic clk = 1'b0, rst = 1'b1, por = 1'b1, ee_present = 1'b1, emu_en = 1'b0;
  logic protect = 1'b0, sw_wr = 1'b0, sw_led = 1'b0, attr_wr = 1'b0, ee_valid = 1'b0;
  logic [7:0] sw_cfg_attr = 8'h00, ee_rdata = 8'h00, next_addr = 8'h00;
  logic [MAC_HI_W-1:0] sw_hi = '0;
  logic [MAC_LO_W-1:0] sw_lo = '0;
  logic [WAKE_W-1:0] sw_wake = '0;
  logic [LEN_W-1:0] sw_hs = '0, sw_fs = '0;
  logic [FLAG_W-1:0] sw_flags = '0;
  logic ee_rd, led_function_select, remote_wakeup_flag, source_is_ram, load_done;
  logic [7:0] ee_addr;
  logic [MAC_HI_W-1:0] mac_address_high;
  logic [MAC_LO_W-1:0] mac_address_low;
  logic [WAKE_W-1:0] gpio_wake_enable_n;
  logic [LEN_W-1:0] high_speed_desc_lengths, full_speed_desc_lengths;
  logic [FLAG_W-1:0] flag_attribute_reg, flag_readback;
  int num_errors = 0, num_checks = 0, reads = 0;

  cfg_source u_dut (
    .clk, .rst, .por, .eeprom_present(ee_present), .eeprom_emulation_enable(emu_en),
    .reset_protect(protect), .sw_wr, .sw_mac_address_high(sw_hi), .sw_mac_address_low(sw_lo),
    .sw_led_function_select(sw_led), .sw_gpio_wake_enable_n(sw_wake),
    .sw_high_speed_desc_lengths(sw_hs), .sw_full_speed_desc_lengths(sw_fs),
    .sw_flag_attribute_reg(sw_flags), .sw_cfg_attr_wr(attr_wr), .sw_cfg_attr,
    .ee_rd, .ee_addr, .ee_valid, .ee_rdata, .mac_address_high, .mac_address_low,
    .led_function_select, .gpio_wake_enable_n, .high_speed_desc_lengths,
    .full_speed_desc_lengths, .flag_attribute_reg, .flag_readback, .remote_wakeup_flag,
    .source_is_ram, .load_done
  );

  // 50 mhz clock
  initial
  begin
    forever #10 clk = ~clk;
  end

  // image byte seen at each eeprom address
  function automatic logic [7:0] img(input logic [7:0] a);
    return a ^ 8'h5e;
  endfunction

  task automatic check(input logic [63:0] seen, input logic [63:0] exp);
    num_checks++;
    if (seen !== exp)
    begin
      num_errors++;
      $display("ERROR %0t: got %h want %h", $time, seen, exp);
    end
  endtask

  task test_done;
    if (num_errors == 0 && num_checks > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask

  // eeprom answers one cycle after each read; idle data toggles so stale bytes show
  always @(posedge clk)
  begin
    ee_valid <= ee_rd;
    ee_rdata <= ee_rd ? img(ee_addr) : ~ee_rdata;
    if (rst)
    begin
      next_addr <= 8'h00;
      reads <= 0;
    end
    else if (ee_rd === 1'b1)
    begin
      check(ee_addr, next_addr);
      next_addr <= next_addr + 8'h01;
      reads <= reads + 1;
    end
  end

  // five-cycle reset, then wait for the source decision
  task do_reset(input logic p);
    rst <= 1'b1;
    por <= p;
    repeat (5) @(posedge clk);
    rst <= 1'b0;
    por <= 1'b0;
    for (int i = 0; i < 12 && source_is_ram !== emu_en; i++)
      @(posedge clk);
    repeat (2) @(posedge clk);
  endtask

  // full software setting load, one strobe
  task sw_write(input logic [7:0] b);
    sw_hi <= {b, ~b};
    sw_lo <= {b, 8'h3c, ~b, 8'hc3};
    sw_led <= b[0];
    sw_wake <= {b[2:0], ~b};
    sw_hs <= {24'h120009, b};
    sw_fs <= '0;
    sw_flags <= b;
    sw_wr <= 1'b1;
    @(posedge clk);
    sw_wr <= 1'b0;
    repeat (2) @(posedge clk);
  endtask

  // configuration attributes byte of a word-aligned descriptor in ram
  task attr_write(input logic [7:0] a);
    sw_cfg_attr <= a;
    attr_wr <= 1'b1;
    @(posedge clk);
    attr_wr <= 1'b0;
    repeat (2) @(posedge clk);
  endtask

  task check_sw;
    check(mac_address_high, sw_hi);
    check(mac_address_low, sw_lo);
    check(led_function_select, sw_led);
    check(gpio_wake_enable_n, sw_wake);
    check(high_speed_desc_lengths, sw_hs);
    check(full_speed_desc_lengths, sw_fs);
    check(flag_attribute_reg, sw_flags);
    check(flag_readback, sw_flags);
  endtask

  // outputs against the eeprom image
  task check_ee;
    logic [47:0] m;
    logic [7:0] c, w, f;
    c = img(EE_CFG);
    w = img(EE_WAKE_HI);
    f = img(EE_HIGH_SPEED_DESC_LENGTHS);
    for (int i = 0; i < 6; i++)
      m[8*i +: 8] = img(EE_MAC_BASE + 8'(i));
    check(mac_address_low, m[31:0]);
    check(mac_address_high, m[47:32]);
    check(led_function_select, c[LED_FUNCTION_SELECT_BIT]);
    check(gpio_wake_enable_n, {w[2:0], img(EE_WAKE_LO)});
    check(high_speed_desc_lengths[7:0], img(EE_HS_LEN));
    check(full_speed_desc_lengths[7:0], img(EE_FS_LEN));
    check(flag_attribute_reg, img(EE_FLAGS));
    check(flag_readback, 8'h00);
    check(remote_wakeup_flag, f[WAKEUP_BIT]);
    check(source_is_ram, 1'b0);
  endtask

  initial
  begin
    // eeprom boot: image read in order, host area never fetched
    do_reset(1'b1);
    for (int i = 0; i < 3000 && load_done !== 1'b1; i++)
      @(posedge clk);
    repeat (20) @(posedge clk);
    check(reads, 148);
    check(load_done, 1'b1);
    check_ee;
    // software writes must not reach eeprom-sourced settings
    sw_write(8'ha7);
    attr_write(8'h00);
    check_ee;
    // ram boot: attributes refused until the settings load
    emu_en <= 1'b1;
    do_reset(1'b1);
    check(source_is_ram, 1'b1);
    check(load_done, 1'b1);
    attr_write(8'h20);
    check(remote_wakeup_flag, 1'b0);
    sw_write(8'h5b);
    check_sw;
    attr_write(8'h20);
    check(remote_wakeup_flag, 1'b1);
    attr_write(8'h00);
    check(remote_wakeup_flag, 1'b0);
    check(reads, 0);
    // protected warm reset keeps settings, power-on clears them
    protect <= 1'b1;
    do_reset(1'b0);
    check_sw;
    do_reset(1'b1);
    check(mac_address_low, 32'h0);
    check(flag_attribute_reg, 8'h00);
    test_done;
  end

  // watchdog: the tests need under 2000 cycles
  initial
  begin
    repeat (6000) @(posedge clk);
    num_errors++;
    test_done;
  end
endmodule
`default_nettype wire
